/* File: mscd_activity_detect.sv */
// mscd_activity_detect: flags transitions of one input per window
`timescale 1ns/1ps
module mscd_activity_detect (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sig,
    input wire logic window_tick,
    output logic detect
);
    logic sig_prev;
    logic seen;
    logic edge_now;
    logic primed;

    // no edge counts until one real sample is held: a line idling high
    // would otherwise look active in the first window after reset
    assign edge_now = primed & (sig ^ sig_prev);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sig_prev <= 1'b0;
            primed <= 1'b0;
        end else begin
            sig_prev <= sig;
            primed <= 1'b1;
        end
    end

    // a level held high or low never makes an edge, so reads inactive
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seen <= 1'b0;
            detect <= 1'b0;
        end else if (window_tick) begin
            detect <= seen | edge_now;
            seen <= 1'b0;
        end else if (edge_now) begin
            seen <= 1'b1;
        end
    end
endmodule : mscd_activity_detect

/* File: mscd_mode_sync_ctrl.sv */
// mscd_mode_sync_ctrl: mode registers, sync detection, interface choice
`timescale 1ns/1ps
// How it works
// - clamp polarity 0 clamps while clamp input high; 1 reverses; resets 1.
// - clock source 0 uses PLL from hsync; 1 uses external pin, divide ignored.
// - per-channel clamp reference bits red 2, green 1, blue 0; 1 is midscale.
// - data clock invert, digital only; default 0 launches on trailing edge.
// - pixel select 0 one pixel per clock even port; 1 splits even and odd.
// - drive field 11 high, 10 medium, 0x low; default 11.
// - three-state bit floats data and data clock outputs; default 0.
// - sync detect pin is 1 on activity with polarity 0, else inverted.
// - hsync detect reads 1 only when hsync toggles.
// - sync-on-green detect reads 1 on activity, video may trigger it.
// - vsync detect reads 1 only when vsync toggles.
// - digital clock detect reads 1 when the link clock toggles.
// - analog detected is any sync detect; digital is clock detect.
// - auto choice: analog 0, digital 1, both priority bit, none seek.
// - override forces the active interface to the priority bit.
// - external clamp used only when clamp source bit is 1.
// - override and priority bits reset to 0, analog wins by default.
module mscd_mode_sync_ctrl #(
    parameter int WINDOW_CYCLES = mscd_pkg::ACTIVITY_WINDOW_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hsync_in,
    input wire logic sog_in,
    input wire logic vsync_in,
    input wire logic digital_clock_in,
    input wire logic ext_clamp_in,
    input wire logic internal_clamp,
    output logic clamp_active,
    output mscd_pkg::mscd_output_ctrl_type out_ctrl,
    output logic sync_detect_pin,
    output logic active_interface_result,
    output logic seek_mode,
    output logic irq
);
    // ------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------
    logic [7:0] clamp_reg;
    logic [7:0] mode_reg;
    logic [7:0] ifc_reg;
    logic [4:0] irq_status;
    logic [4:0] irq_mask;
    logic [3:0] det;
    logic [3:0] det_prev;
    logic ai_prev;
    logic [31:0] win_cnt;
    logic window_tick;
    mscd_pkg::mscd_bus_state_type bus_state;
    logic [7:0] idx;
    logic wr_ok;
    logic analog_det;
    logic digital_det;
    logic next_ai;
    logic next_seek;
    logic [7:0] status_byte;
    logic [4:0] irq_set;
    logic [31:0] next_rdata;

    assign idx = avs_address[9:2];
    assign wr_ok = avs_write && bus_state == mscd_pkg::BUS_ACK;

    // ------------------------------------------------------------
    // activity detection
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt <= 32'h0;
            window_tick <= 1'b0;
        end else if (win_cnt >= 32'(WINDOW_CYCLES - 1)) begin
            win_cnt <= 32'h0;
            window_tick <= 1'b1;
        end else begin
            win_cnt <= win_cnt + 32'h1;
            window_tick <= 1'b0;
        end
    end

    mscd_activity_detect u_hsync (
        .clk(clk), .resetn(resetn), .sig(hsync_in),
        .window_tick(window_tick), .detect(det[3])
    );
    // green video edges count too: no sync qualification here
    mscd_activity_detect u_sog (
        .clk(clk), .resetn(resetn), .sig(sog_in),
        .window_tick(window_tick), .detect(det[2])
    );
    mscd_activity_detect u_vsync (
        .clk(clk), .resetn(resetn), .sig(vsync_in),
        .window_tick(window_tick), .detect(det[1])
    );
    // clock is sampled as data, so it must run below half of clk
    mscd_activity_detect u_dclk (
        .clk(clk), .resetn(resetn), .sig(digital_clock_in),
        .window_tick(window_tick), .detect(det[0])
    );

    // ------------------------------------------------------------
    // active interface decision
    // ------------------------------------------------------------
    always_comb begin
        analog_det = det[3] | det[2] | det[1];
        digital_det = det[0];
        next_seek = 1'b0;
        if (ifc_reg[mscd_pkg::POS_IF_OVERRIDE]) begin
            next_ai = ifc_reg[mscd_pkg::POS_IF_PRIORITY];
        end else if (analog_det && digital_det) begin
            next_ai = ifc_reg[mscd_pkg::POS_IF_PRIORITY];
        end else if (digital_det) begin
            next_ai = 1'b1;
        end else if (analog_det) begin
            next_ai = 1'b0;
        end else begin
            next_ai = active_interface_result;
            next_seek = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_interface_result <= 1'b0;
            seek_mode <= 1'b0;
            sync_detect_pin <= 1'b0;
        end else begin
            active_interface_result <= next_ai;
            seek_mode <= next_seek;
            sync_detect_pin <= (analog_det | digital_det)
                ^ mode_reg[mscd_pkg::POS_SD_POL];
        end
    end

    // ------------------------------------------------------------
    // clamp and output controls
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clamp_active <= 1'b0;
        end else if (clamp_reg[mscd_pkg::POS_CLAMP_SOURCE]) begin
            clamp_active <= ext_clamp_in
                ^ clamp_reg[mscd_pkg::POS_CLAMP_POL];
        end else begin
            clamp_active <= internal_clamp;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_ctrl <= '0;
            out_ctrl.drive_level <= mscd_pkg::DRIVE_HIGH;
        end else begin
            out_ctrl.data_clock_invert <=
                mode_reg[mscd_pkg::POS_CLK_INVERT];
            out_ctrl.two_pixels_per_clock <=
                mode_reg[mscd_pkg::POS_PIX_SELECT];
            out_ctrl.drive_level <= mscd_pkg::drive_decode(
                mode_reg[mscd_pkg::POS_DRIVE_HI:mscd_pkg::POS_DRIVE_LO]);
            out_ctrl.output_tristate_control <=
                mode_reg[mscd_pkg::POS_TRISTATE];
            out_ctrl.pixel_clock_source_select <=
                clamp_reg[mscd_pkg::POS_PIXCLK_SRC];
            out_ctrl.pll_divide_ratio_ignored <=
                clamp_reg[mscd_pkg::POS_PIXCLK_SRC];
            out_ctrl.clamp_midscale <= clamp_reg[
                mscd_pkg::POS_CLAMP_RED:mscd_pkg::POS_CLAMP_BLUE];
        end
    end

    // ------------------------------------------------------------
    // bus slave: one wait cycle, then the access completes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= mscd_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (bus_state)
                mscd_pkg::BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state <= mscd_pkg::BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                mscd_pkg::BUS_ACK: begin
                    bus_state <= mscd_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state <= mscd_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // writes to the status index fall through: nothing there is writable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clamp_reg <= mscd_pkg::RST_CLAMP_CLOCK;
            mode_reg <= mscd_pkg::RST_OUTPUT_MODE;
            ifc_reg <= mscd_pkg::RST_IF_CONTROL;
            irq_mask <= mscd_pkg::RST_IRQ_MASK;
        end else if (wr_ok) begin
            if (idx == mscd_pkg::IDX_CLAMP_CLOCK) begin
                clamp_reg <= {2'b00, avs_writedata[5:0]};
            end else if (idx == mscd_pkg::IDX_OUTPUT_MODE) begin
                mode_reg <= {avs_writedata[7:2], 2'b00};
            end else if (idx == mscd_pkg::IDX_IF_CONTROL) begin
                ifc_reg <= {avs_writedata[7:6], 6'b000000};
            end else if (idx == mscd_pkg::IDX_IRQ_MASK) begin
                irq_mask <= avs_writedata[4:0];
            end
        end
    end

    always_comb begin
        status_byte = '0;
        status_byte[mscd_pkg::POS_HSYNC_DET] = det[3];
        status_byte[mscd_pkg::POS_SOG_DET] = det[2];
        status_byte[mscd_pkg::POS_VSYNC_DET] = det[1];
        status_byte[mscd_pkg::POS_DCLK_DET] = det[0];
        status_byte[mscd_pkg::POS_ACTIVE_IF] = active_interface_result;
        next_rdata = '0;
        if (idx == mscd_pkg::IDX_CLAMP_CLOCK) begin
            next_rdata[7:0] = clamp_reg;
        end else if (idx == mscd_pkg::IDX_OUTPUT_MODE) begin
            next_rdata[7:0] = mode_reg;
        end else if (idx == mscd_pkg::IDX_SYNC_STATUS) begin
            next_rdata[7:0] = status_byte;
        end else if (idx == mscd_pkg::IDX_IF_CONTROL) begin
            next_rdata[7:0] = ifc_reg;
        end else if (idx == mscd_pkg::IDX_IRQ_STATUS) begin
            next_rdata[4:0] = irq_status;
        end else if (idx == mscd_pkg::IDX_IRQ_MASK) begin
            next_rdata[4:0] = irq_mask;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0;
        end else if (bus_state == mscd_pkg::BUS_IDLE && avs_read) begin
            avs_readdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // interrupts: new activity per input, active interface change
    // ------------------------------------------------------------
    always_comb begin
        irq_set = '0;
        irq_set[3:0] = det & ~det_prev;
        irq_set[mscd_pkg::POS_IRQ_AI_CHANGE] =
            active_interface_result ^ ai_prev;
    end

    // a set in the clearing cycle wins so no event is lost
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            det_prev <= 4'h0;
            ai_prev <= 1'b0;
            irq_status <= 5'h00;
            irq <= 1'b0;
        end else begin
            det_prev <= det;
            ai_prev <= active_interface_result;
            if (wr_ok && idx == mscd_pkg::IDX_IRQ_STATUS) begin
                irq_status <= (irq_status & ~avs_writedata[4:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_clamp_polarity: assert property (
        clamp_reg[mscd_pkg::POS_CLAMP_SOURCE]
        && !clamp_reg[mscd_pkg::POS_CLAMP_POL] |=> clamp_active
            == $past(ext_clamp_in)
    ) else $error("external clamp sense wrong");

    a_clamp_source_gate: assert property (
        !clamp_reg[mscd_pkg::POS_CLAMP_SOURCE] |=>
            clamp_active == $past(internal_clamp)
    ) else $error("internal clamp not followed");

    a_pixclk_source: assert property (
        clamp_reg[mscd_pkg::POS_PIXCLK_SRC] |=>
            out_ctrl.pixel_clock_source_select
            && out_ctrl.pll_divide_ratio_ignored
    ) else $error("external pixel clock not selected");

    a_drive_decode: assert property (
        mode_reg[mscd_pkg::POS_DRIVE_HI:mscd_pkg::POS_DRIVE_LO] == 2'b10
        |=> out_ctrl.drive_level == mscd_pkg::DRIVE_MEDIUM
    ) else $error("medium drive not decoded");

    a_tristate_follow: assert property (
        $rose(mode_reg[mscd_pkg::POS_TRISTATE]) |=>
            out_ctrl.output_tristate_control
    ) else $error("three-state not applied");

    a_sync_pin_pol: assert property (
        det[0] && !mode_reg[mscd_pkg::POS_SD_POL] |=> sync_detect_pin
    ) else $error("sync detect pin polarity wrong");

    a_detect_window: assert property (
        $rose(det[3]) |-> $past(window_tick)
    ) else $error("hsync detect changed off window");

    a_auto_digital: assert property (
        !ifc_reg[mscd_pkg::POS_IF_OVERRIDE] && det[0] && !det[3]
        && !det[2] && !det[1] |=> active_interface_result && !seek_mode
    ) else $error("digital only must select digital");

    a_seek_mode: assert property (
        !ifc_reg[mscd_pkg::POS_IF_OVERRIDE] && det == 4'h0 |=> seek_mode
    ) else $error("no activity must enter seek mode");

    a_override_select: assert property (
        ifc_reg[mscd_pkg::POS_IF_OVERRIDE] |=> active_interface_result
            == $past(ifc_reg[mscd_pkg::POS_IF_PRIORITY])
    ) else $error("override ignored");

    a_status_readonly: assert property (
        wr_ok && idx == mscd_pkg::IDX_SYNC_STATUS && !window_tick
        |=> $stable(det)
    ) else $error("status write changed detection");

    a_irq_level: assert property (
        |(irq_status & irq_mask) |=> irq
    ) else $error("interrupt not raised");

endmodule : mscd_mode_sync_ctrl

/* File: mscd_pkg.sv */
// mscd_pkg: register map, field positions, reset values and types
package mscd_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CLAMP_CLOCK = 8'h0F;
    localparam logic [7:0] IDX_OUTPUT_MODE = 8'h10;
    localparam logic [7:0] IDX_SYNC_STATUS = 8'h11;
    localparam logic [7:0] IDX_IF_CONTROL = 8'h12;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_CLAMP_SOURCE = 5;
    localparam int POS_CLAMP_POL = 4;
    localparam int POS_PIXCLK_SRC = 3;
    localparam int POS_CLAMP_RED = 2;
    localparam int POS_CLAMP_GREEN = 1;
    localparam int POS_CLAMP_BLUE = 0;
    localparam int POS_CLK_INVERT = 7;
    localparam int POS_PIX_SELECT = 6;
    localparam int POS_DRIVE_HI = 5;
    localparam int POS_DRIVE_LO = 4;
    localparam int POS_TRISTATE = 3;
    localparam int POS_SD_POL = 2;
    localparam int POS_HSYNC_DET = 7;
    localparam int POS_SOG_DET = 6;
    localparam int POS_VSYNC_DET = 5;
    localparam int POS_DCLK_DET = 4;
    localparam int POS_ACTIVE_IF = 3;
    localparam int POS_IF_OVERRIDE = 7;
    localparam int POS_IF_PRIORITY = 6;
    localparam int IRQ_BITS = 5;
    localparam int POS_IRQ_AI_CHANGE = 4;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CLAMP_CLOCK = 8'h10;
    localparam logic [7:0] RST_OUTPUT_MODE = 8'h30;
    localparam logic [7:0] RST_IF_CONTROL = 8'h00;
    localparam logic [4:0] RST_IRQ_MASK = 5'h00;
    localparam int ACTIVITY_WINDOW_US = 500;
    localparam int CLK_MHZ = 200;
    localparam int ACTIVITY_WINDOW_CYCLES = ACTIVITY_WINDOW_US * CLK_MHZ;

    typedef enum logic [1:0] {
        DRIVE_LOW = 2'b00,
        DRIVE_MEDIUM = 2'b01,
        DRIVE_HIGH = 2'b10
    } mscd_drive_type;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } mscd_bus_state_type;

    typedef struct packed {
        logic data_clock_invert;
        logic two_pixels_per_clock;
        mscd_drive_type drive_level;
        logic output_tristate_control;
        logic pixel_clock_source_select;
        logic pll_divide_ratio_ignored;
        logic [2:0] clamp_midscale;
    } mscd_output_ctrl_type;

    function automatic mscd_drive_type drive_decode(input logic [1:0] f);
        if (!f[1]) begin
            return DRIVE_LOW;
        end else if (f[0]) begin
            return DRIVE_HIGH;
        end else begin
            return DRIVE_MEDIUM;
        end
    endfunction : drive_decode

endpackage : mscd_pkg

/* File: mscd_source_model.sv */
// mscd_source_model: graphics source toggling sync and link clock lines
`timescale 1ns/1ps
module mscd_source_model (
    input wire logic clk,
    input wire logic [3:0] run,
    output logic hsync_in,
    output logic sog_in,
    output logic vsync_in,
    output logic digital_clock_in
);
    // ----------------------------------------------------------------
    // line activity
    // ----------------------------------------------------------------
    // a stopped line holds its level: a held sync must not look active
    int unsigned cnt = 0;
    initial begin
        hsync_in = 1'b1;
        sog_in = 1'b0;
        vsync_in = 1'b1;
        digital_clock_in = 1'b0;
    end
    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (run[3] && cnt % 3 == 0) hsync_in <= !hsync_in;
        if (run[2] && cnt % 5 == 0) sog_in <= !sog_in;
        if (run[1] && cnt % 7 == 0) vsync_in <= !vsync_in;
        // link clock at 50 MHz, below the detector's limit
        if (run[0] && cnt % 2 == 0) digital_clock_in <= !digital_clock_in;
    end
endmodule : mscd_source_model

/* File: testbench.sv */
// testbench: registers, clamp, detection, interface choice, interrupt
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    localparam int WIN = 16;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic hsync_in, sog_in, vsync_in, digital_clock_in;
    logic ext_clamp_in = 1'b0;
    logic internal_clamp = 1'b0;
    logic clamp_active, sync_detect_pin, active_interface_result;
    logic seek_mode, irq;
    logic [3:0] run = 4'h0;
    mscd_pkg::mscd_output_ctrl_type out_ctrl;
    int n_errors = 0;
    int num_checks = 0;

    mscd_mode_sync_ctrl #(.WINDOW_CYCLES(WIN)) dut (
        .clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hsync_in(hsync_in),
        .sog_in(sog_in), .vsync_in(vsync_in),
        .digital_clock_in(digital_clock_in), .ext_clamp_in(ext_clamp_in),
        .internal_clamp(internal_clamp), .clamp_active(clamp_active),
        .out_ctrl(out_ctrl), .sync_detect_pin(sync_detect_pin),
        .active_interface_result(active_interface_result),
        .seek_mode(seek_mode), .irq(irq));
    mscd_source_model src (.clk(clk), .run(run), .hsync_in(hsync_in),
        .sog_in(sog_in), .vsync_in(vsync_in),
        .digital_clock_in(digital_clock_in));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // the leading edge keeps one idle cycle between two requests
    task automatic bus(input logic wr, input logic [7:0] idx,
            input logic [7:0] wd, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk("bus wait", 32'h2, 32'(n));
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] idx,
            input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(what, exp, q & mask);
    endtask : rdc

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk("out_ctrl reset", 32'h080, 32'(out_ctrl));
        chk("sync pin reset", 32'h0, 32'(sync_detect_pin));
        rdc("clamp reg", mscd_pkg::IDX_CLAMP_CLOCK, 32'h10, '1);
        rdc("mode reg", mscd_pkg::IDX_OUTPUT_MODE, 32'h30, '1);
        rdc("if reg", mscd_pkg::IDX_IF_CONTROL, 32'h00, '1);
        wr(8'h05, 8'hFF);
        rdc("unmapped", 8'h05, 32'h0, '1);
    endtask : t_reset

    task automatic t_ctrl;
        logic [1:0] d;
        wr(mscd_pkg::IDX_CLAMP_CLOCK, 8'hFF);
        rdc("clamp rw", mscd_pkg::IDX_CLAMP_CLOCK, 32'h3F, '1);
        repeat (2) @(posedge clk);
        chk("src refs", 32'h1F, 32'(out_ctrl[4:0]));
        wr(mscd_pkg::IDX_CLAMP_CLOCK, 8'h05);
        repeat (2) @(posedge clk);
        chk("src refs", 32'h05, 32'(out_ctrl[4:0]));
        for (int i = 0; i < 4; i++) begin
            wr(mscd_pkg::IDX_OUTPUT_MODE, 8'hCD | 8'(i << 4));
            rdc("mode rw", mscd_pkg::IDX_OUTPUT_MODE, 32'hCC | (i << 4), '1);
            repeat (2) @(posedge clk);
            d = (i < 2) ? 2'b00 : (i == 2) ? 2'b01 : 2'b10;
            chk("drive", 32'(d), 32'(out_ctrl.drive_level));
            chk("flags", 32'h7, 32'({out_ctrl[9:8], out_ctrl[5]}));
            chk("sync pin pol", 32'h1, 32'(sync_detect_pin));
        end
        wr(mscd_pkg::IDX_OUTPUT_MODE, 8'h30);
        repeat (2) @(posedge clk);
        chk("flags off", 32'h0, 32'({out_ctrl[9:8], out_ctrl[5]}));
    endtask : t_ctrl

    task automatic t_clamp;
        logic e;
        for (int i = 0; i < 8; i++) begin
            wr(mscd_pkg::IDX_CLAMP_CLOCK, {2'b00, i[2], i[1], 4'h0});
            ext_clamp_in <= i[0];
            internal_clamp <= !i[0];
            repeat (3) @(posedge clk);
            e = i[2] ? (i[0] ^ i[1]) : !i[0];
            chk("clamp", 32'(e), 32'(clamp_active));
        end
        wr(mscd_pkg::IDX_CLAMP_CLOCK, 8'h10);
    endtask : t_clamp

    // each entry: [4] priority bit, [3:0] lines running
    task automatic t_detect;
        logic [4:0] cs [9] = '{5'h00, 5'h08, 5'h04, 5'h02, 5'h01, 5'h09,
            5'h19, 5'h11, 5'h00};
        logic ana, dig, ai;
        ai = 1'b0;
        foreach (cs[k]) begin
            wr(mscd_pkg::IDX_IF_CONTROL, {1'b0, cs[k][4], 6'h0});
            run <= cs[k][3:0];
            repeat (4 * WIN) @(posedge clk);
            ana = |cs[k][3:1];
            dig = cs[k][0];
            if (ana || dig) ai = (ana && dig) ? cs[k][4] : dig;
            rdc("status", mscd_pkg::IDX_SYNC_STATUS, 32'({cs[k][3:0], ai,
                3'b000}), 32'hF8);
            chk("seek", 32'(!(ana || dig)), 32'(seek_mode));
            chk("ai pin", 32'(ai), 32'(active_interface_result));
            chk("sync pin", 32'(ana || dig), 32'(sync_detect_pin));
        end
        wr(mscd_pkg::IDX_SYNC_STATUS, 8'hFF);
        rdc("status ro", mscd_pkg::IDX_SYNC_STATUS, 32'h08, 32'hF8);
    endtask : t_detect

    task automatic t_override;
        run <= 4'b1000;
        wr(mscd_pkg::IDX_IF_CONTROL, 8'hFF);
        rdc("if rw", mscd_pkg::IDX_IF_CONTROL, 32'hC0, '1);
        repeat (4 * WIN) @(posedge clk);
        chk("forced digital", 32'h1, 32'(active_interface_result));
        run <= 4'b0001;
        wr(mscd_pkg::IDX_IF_CONTROL, 8'h80);
        repeat (4 * WIN) @(posedge clk);
        chk("forced analog", 32'h0, 32'(active_interface_result));
        run <= 4'b0000;
        repeat (4 * WIN) @(posedge clk);
        chk("no seek forced", 32'h0, 32'(seek_mode));
        wr(mscd_pkg::IDX_IF_CONTROL, 8'h00);
    endtask : t_override

    task automatic t_irq;
        wr(mscd_pkg::IDX_IRQ_MASK, 8'h00);
        wr(mscd_pkg::IDX_IRQ_STATUS, 8'h1F);
        rdc("irq clear", mscd_pkg::IDX_IRQ_STATUS, 32'h0, '1);
        run <= 4'b1000;
        repeat (4 * WIN) @(posedge clk);
        rdc("irq hsync", mscd_pkg::IDX_IRQ_STATUS, 32'h08, '1);
        chk("irq masked", 32'h0, 32'(irq));
        wr(mscd_pkg::IDX_IRQ_MASK, 8'h08);
        rdc("mask rw", mscd_pkg::IDX_IRQ_MASK, 32'h08, '1);
        chk("irq raised", 32'h1, 32'(irq));
        wr(mscd_pkg::IDX_IRQ_STATUS, 8'h08);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        run <= 4'b0001;
        repeat (4 * WIN) @(posedge clk);
        rdc("irq ai change", mscd_pkg::IDX_IRQ_STATUS, 32'h11, '1);
        wr(mscd_pkg::IDX_IRQ_MASK, 8'h10);
        repeat (3) @(posedge clk);
        chk("irq ai", 32'h1, 32'(irq));
        run <= 4'b0000;
    endtask : t_irq

    // ----------------------------------------------------------------
    // sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        chk("watchdog", 32'h0, 32'h1);
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_ctrl();
        t_clamp();
        t_detect();
        t_override();
        t_irq();
        stop_test();
    end
endmodule : testbench
